// [channel_fault_timers.sv]
// Top of the six-channel fault timer block
// Function
// - On-state blanking 6, 12, 24 or 48 us by two-bit select.
// - On-state blanking select resets to code 10, 24 us.
// - On blanking starts at channel input rising edge, before fault flag.
// - Off-state blanking 55, 81, 162 or 325 us by two-bit select.
// - Off-state blanking select resets to code 10, 162 us.
// - Off blanking starts at channel input falling edge.
// - Fault must persist 3 us on, 55 us off before report.
// - Channels with retry bit set re-enable within one 8 ms retry period.
// - One global retry timer serves all channels.
// - Reset loads defaults, clears status, releases fault flag.
`timescale 1ns/1ns
`include "fault_timers_map.svh"

module channel_fault_timers
#(
    parameter int RETRY_TICKS = `TICKS_OF_US(`RETRY_PERIOD_US)
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic config_write,
    input wire fault_timers_pkg::timer_config_t config_in,
    input wire logic [5:0] parallel_channel_input,
    input wire logic [5:0] drain_feedback,
    output logic fault_flag_n,
    output logic fault_flag_oe,
    output logic [5:0] channel_fault_q,
    output fault_timers_pkg::timer_config_t config_q
);
    localparam logic [4:0] DIV_LAST = 5'(`TIMER_TICK_DIV - 1);

    logic [4:0] div_q;
    logic tick_q;
    logic [15:0] retry_q;
    logic retry_release_q;
    logic [15:0] on_blank_ticks;
    logic [15:0] off_blank_ticks;
    logic [5:0] fault_w;

    // 4 MHz timer tick from the 100 MHz clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= 5'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= div_q == DIV_LAST;
            div_q <= (div_q == DIV_LAST) ? 5'h00 : div_q + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            config_q.on_blank_select <= `ON_BLANK_RESET;
            config_q.off_blank_select <= `OFF_BLANK_RESET;
            config_q.retry_mode_bits <= `RETRY_MODE_RESET;
        end
        else if (config_write)
            config_q <= config_in;
    end

    always_comb
    begin
        case (config_q.on_blank_select)
            2'h0: on_blank_ticks = 16'(`TICKS_OF_NS(`ON_BLANK_NS_00));
            2'h1: on_blank_ticks = 16'(`TICKS_OF_NS(`ON_BLANK_NS_01));
            2'h2: on_blank_ticks = 16'(`TICKS_OF_NS(`ON_BLANK_NS_10));
            default: on_blank_ticks = 16'(`TICKS_OF_NS(`ON_BLANK_NS_11));
        endcase
        case (config_q.off_blank_select)
            2'h0: off_blank_ticks = 16'(`TICKS_OF_NS(`OFF_BLANK_NS_00));
            2'h1: off_blank_ticks = 16'(`TICKS_OF_NS(`OFF_BLANK_NS_01));
            2'h2: off_blank_ticks = 16'(`TICKS_OF_NS(`OFF_BLANK_NS_10));
            default: off_blank_ticks = 16'(`TICKS_OF_NS(`OFF_BLANK_NS_11));
        endcase
    end

    // Free-running shared retry timer; a retrying channel waits up to one period
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            retry_q <= 16'h0000;
            retry_release_q <= 1'b0;
        end
        else
        begin
            retry_release_q <= 1'b0;
            if (tick_q)
            begin
                if (retry_q >= 16'(RETRY_TICKS - 1))
                begin
                    retry_q <= 16'h0000;
                    retry_release_q <= 1'b1;
                end
                else
                    retry_q <= retry_q + 16'h0001;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `CHANNELS; ch++)
        begin : g_chan
            fault_channel u_chan
            (
                .clk(clk),
                .rst(rst),
                .tick(tick_q),
                .channel_in(parallel_channel_input[ch]),
                .drain_fault(drain_feedback[ch]),
                .on_blank_ticks(on_blank_ticks),
                .off_blank_ticks(off_blank_ticks),
                .retry_enable(config_q.retry_mode_bits[ch]),
                .retry_release(retry_release_q),
                .fault_q(fault_w[ch])
            );
        end
    endgenerate

    // Open-drain flag: pulls low while any channel reports a fault
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            channel_fault_q <= 6'h00;
            fault_flag_oe <= 1'b0;
            fault_flag_n <= 1'b1;
        end
        else
        begin
            channel_fault_q <= fault_w;
            fault_flag_oe <= |fault_w;
            fault_flag_n <= 1'b0;
        end
    end

endmodule // channel_fault_timers

// [fault_timers_map.svh]
// Timing counts and configuration defaults for the channel fault timers
`ifndef FAULT_TIMERS_MAP_SVH
`define FAULT_TIMERS_MAP_SVH

`define CLK_MHZ 100
`define TIMER_TICK_DIV 25
`define TIMER_CLK_KHZ 4000
`define ON_BLANK_NS_00 6000
`define ON_BLANK_NS_01 12000
`define ON_BLANK_NS_10 24000
`define ON_BLANK_NS_11 48000
`define OFF_BLANK_NS_00 55000
`define OFF_BLANK_NS_01 81000
`define OFF_BLANK_NS_10 162000
`define OFF_BLANK_NS_11 325000
`define ON_FILTER_NS 3000
`define OFF_FILTER_NS 55000
`define RETRY_PERIOD_US 8000
`define TICKS_OF_NS(t) ((t) * `TIMER_CLK_KHZ / 1000000)
`define TICKS_OF_US(t) ((t) * `TIMER_CLK_KHZ / 1000)
`define ON_BLANK_RESET 2'h2
`define OFF_BLANK_RESET 2'h2
`define RETRY_MODE_RESET 6'h00
`define CHANNELS 6

`endif

// [fault_timers_pkg.sv]
// Types shared by the channel fault timer design
package fault_timers_pkg;

    typedef struct packed {
        logic [1:0] on_blank_select;
        logic [1:0] off_blank_select;
        logic [5:0] retry_mode_bits;
    } timer_config_t;

    typedef enum logic [3:0] {
        CH_IDLE = 4'b0001,
        CH_BLANK = 4'b0010,
        CH_FILTER = 4'b0100,
        CH_FAULT = 4'b1000
    } chan_state_t;

endpackage

// [fault_channel.sv]
// One channel: blanking, filtering and fault latch with retry release
`timescale 1ns/1ns
`include "fault_timers_map.svh"

module fault_channel
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic channel_in,
    input wire logic drain_fault,
    input wire logic [15:0] on_blank_ticks,
    input wire logic [15:0] off_blank_ticks,
    input wire logic retry_enable,
    input wire logic retry_release,
    output logic fault_q
);
    localparam logic [15:0] ON_FILT = 16'(`TICKS_OF_NS(`ON_FILTER_NS));
    localparam logic [15:0] OFF_FILT = 16'(`TICKS_OF_NS(`OFF_FILTER_NS));

    fault_timers_pkg::chan_state_t state_q;
    logic in_q;
    logic [15:0] count_q;
    logic edge_seen;

    assign edge_seen = channel_in != in_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            in_q <= 1'b0;
        else
            in_q <= channel_in;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= fault_timers_pkg::CH_IDLE;
            count_q <= 16'h0000;
            fault_q <= 1'b0;
        end
        else if (edge_seen && state_q != fault_timers_pkg::CH_FAULT)
        begin
            // Blanking restarts on each input edge outside the fault state, length per direction
            state_q <= fault_timers_pkg::CH_BLANK;
            count_q <= channel_in ? on_blank_ticks : off_blank_ticks;
        end
        else
        begin
            case (state_q)
                fault_timers_pkg::CH_IDLE:
                begin
                    if (drain_fault)
                    begin
                        state_q <= fault_timers_pkg::CH_FILTER;
                        count_q <= in_q ? ON_FILT : OFF_FILT;
                    end
                end
                fault_timers_pkg::CH_BLANK:
                begin
                    if (tick)
                    begin
                        if (count_q <= 16'h0001)
                        begin
                            state_q <= fault_timers_pkg::CH_IDLE;
                            count_q <= 16'h0000;
                        end
                        else
                            count_q <= count_q - 16'h0001;
                    end
                end
                fault_timers_pkg::CH_FILTER:
                begin
                    if (!drain_fault)
                        state_q <= fault_timers_pkg::CH_IDLE;
                    else if (tick)
                    begin
                        if (count_q <= 16'h0001)
                        begin
                            state_q <= fault_timers_pkg::CH_FAULT;
                            fault_q <= 1'b1;
                        end
                        else
                            count_q <= count_q - 16'h0001;
                    end
                end
                fault_timers_pkg::CH_FAULT:
                begin
                    // Latch-off channels stay faulted until reset
                    if (retry_enable && retry_release)
                    begin
                        state_q <= fault_timers_pkg::CH_BLANK;
                        count_q <= in_q ? on_blank_ticks : off_blank_ticks;
                        fault_q <= 1'b0;
                    end
                end
                default:
                    state_q <= fault_timers_pkg::CH_IDLE;
            endcase
        end
    end

endmodule // fault_channel

// [fault_timers_checker_assertions.sv]
// Port assertions for the channel fault timer block
`timescale 1ns/1ns
module fault_timers_checker
#(
    parameter int RETRY_TICKS = 32000
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic config_write,
    input wire fault_timers_pkg::timer_config_t config_in,
    input wire logic [5:0] parallel_channel_input,
    input wire logic [5:0] drain_feedback,
    input wire logic fault_flag_n,
    input wire logic fault_flag_oe,
    input wire logic [5:0] channel_fault_q,
    input wire fault_timers_pkg::timer_config_t config_q
);
    // Off blank ticks per code; bounds allow one tick of slack on each count
    localparam int OFF_T [4] = '{220, 324, 648, 1300};
    logic [15:0] run_q;
    logic [15:0] age_q;
    int need;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst)
        if (rst)
            run_q <= '0;
        else
            run_q <= drain_feedback[0] ? run_q + 16'(run_q != 16'hffff) : '0;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            age_q <= '0;
        else
            age_q <= $changed(parallel_channel_input[0]) ? '0 : age_q + 16'(age_q != 16'hffff);
    assign need = parallel_channel_input[0] ? ((24 << config_q.on_blank_select) + 10) * 25
        : (OFF_T[config_q.off_blank_select] + 218) * 25;
    sequence s_rise;
        !channel_fault_q[0] ##1 channel_fault_q[0];
    endsequence
    AST_LOAD: assert property (config_write |=> config_q == $past(config_in))
        else $error("config not loaded");
    AST_RESET: assert property ($fell(rst) |-> config_q == 10'h280 && !fault_flag_oe)
        else $error("reset state wrong");
    AST_OE: assert property (fault_flag_oe == (|channel_fault_q))
        else $error("flag enable mismatch");
    AST_FLAG: assert property (fault_flag_oe |-> !fault_flag_n)
        else $error("flag level wrong");
    AST_BLANK: assert property (s_rise |-> age_q >= need)
        else $error("fault before blanking");
    AST_FILTER: assert property (s_rise |-> run_q >= (parallel_channel_input[0] ? 275 : 5475))
        else $error("fault before filter");
    AST_HOLD: assert property (channel_fault_q[0] && !config_q[0] |=> channel_fault_q[0])
        else $error("latched fault lost");
    AST_SHARED: assert property ($fell(channel_fault_q[1]) |-> !(|(channel_fault_q & config_q[5:0])))
        else $error("retry release not shared");
endmodule // fault_timers_checker
bind channel_fault_timers fault_timers_checker #(.RETRY_TICKS(RETRY_TICKS)) chk (.clk, .rst,
    .config_write, .config_in, .parallel_channel_input, .drain_feedback, .fault_flag_n,
    .fault_flag_oe, .channel_fault_q, .config_q);

// [host_model.sv]
// Host model driving configuration and channel lines
`timescale 1ns/1ns
module host_model
(
    input wire logic clk,
    output logic cw = 1'b0,
    output logic [9:0] ci = 10'h000,
    output logic [5:0] pin = 6'h00,
    output logic [5:0] dfb = 6'h00
);
    task automatic cfg(input logic [9:0] v);
        @(posedge clk);
        #1 {cw, ci} = {1'b1, v};
        @(posedge clk);
        #1 cw = 1'b0;
    endtask
    task automatic drive(input logic [5:0] p, input logic [5:0] d);
        @(posedge clk);
        #1 {pin, dfb} = {p, d};
    endtask
endmodule // host_model

// [tb.sv]
// Self-checking bench for the channel fault timer block
`timescale 1ns/1ns
module tb;
    logic clk;
    logic rst;
    logic cw;
    logic [9:0] ci;
    logic [5:0] pin;
    logic [5:0] dfb;
    logic fn;
    logic oe;
    logic [5:0] fq;
    logic [9:0] cq;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int off_t [3] = '{220, 324, 1300};
    host_model host (.clk, .cw, .ci, .pin, .dfb);
    channel_fault_timers #(.RETRY_TICKS(40)) dut (.clk, .rst, .config_write(cw), .config_in(ci),
        .parallel_channel_input(pin), .drain_feedback(dfb), .fault_flag_n(fn),
        .fault_flag_oe(oe), .channel_fault_q(fq), .config_q(cq));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string s, input logic [9:0] seen, input logic [9:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
        if (++cyc == 95000)
        begin
            error_cnt++;
            report_and_stop();
        end
    // Lines go idle first so that release brings no false input edge
    task automatic do_reset();
        host.drive(6'h00, 6'h00);
        rst = 1'b1;
        repeat (8) @(posedge clk);
        check("reset out", {fn, oe, fq}, 10'h080);
        check("reset cfg", cq, 10'h280);
        #1 rst = 1'b0;
    endtask
    // Edge to fault report, with a tick of slack each way for the tick phase
    task automatic time_fault(input logic lvl, input int ticks);
        int n;
        n = 0;
        host.drive({5'h00, lvl}, 6'h01);
        while (fq[0] !== 1'b1 && n < 40000)
        begin
            @(posedge clk);
            #1 n++;
        end
        check("delay", 10'(n >= (ticks - 1) * 25 && n <= (ticks + 1) * 25 + 4), 10'h001);
    endtask
    task automatic test_on();
        for (int c = 0; c < 4; c++)
        begin
            do_reset();
            host.cfg({c[1:0], 8'h80});
            time_fault(1'b1, (24 << c) + 12);
        end
    endtask
    task automatic test_off();
        for (int c = 0; c < 3; c++)
        begin
            do_reset();
            host.cfg({2'b00, 2'(c + c / 2), 6'h00});
            host.drive(6'h01, 6'h00);
            repeat (700) @(posedge clk);
            time_fault(1'b0, off_t[c] + 220);
        end
    endtask
    task automatic test_retry();
        int n;
        int t1;
        do_reset();
        host.cfg(10'h086);
        host.drive(6'h03, 6'h03);
        repeat (100) @(posedge clk);
        host.drive(6'h07, 6'h07);
        for (n = 0; fq !== 6'h07 && n < 6000; n++)
            @(posedge clk) #1;
        host.drive(6'h07, 6'h00);
        for (n = 0; fq[1] !== 1'b0 && n < 3000; n++)
            @(posedge clk) #1;
        check("retry", fq, 10'h001);
        // Releases of the shared timer fall a whole number of periods apart
        t1 = cyc;
        host.drive(6'h07, 6'h02);
        for (n = 0; fq[1] !== 1'b1 && n < 3000; n++)
            @(posedge clk) #1;
        for (n = 0; fq[1] !== 1'b0 && n < 3000; n++)
            @(posedge clk) #1;
        check("retry wait", 10'(n < 3000), 10'h001);
        check("retry period", 10'((cyc - t1) % 1000), 10'h000);
    endtask
    initial
    begin
        rst = 1'b1;
        test_on();
        test_off();
        test_retry();
        report_and_stop();
    end
endmodule // tb
